// ==== rtl/pbs_defines.svh ====
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH

// configuration dword holding command (low half) and status (high half)
`define PBS_CFG_DWORD_OFS 8'h04
`define PBS_CMD_OFS 8'h04
`define PBS_STATUS_OFS 8'h06
`define PBS_CMD_RESET 16'h0000
`define PBS_STATUS_RESET 16'h0210
// writable command bits: 9, 8, 6, 5, 2, 1, 0
`define PBS_CMD_WMASK 16'h0367
`define PBS_CMD_SERR_EN 8
`define PBS_CMD_PERR_RESP 6
// fixed status bits: devsel timing 01b, capabilities list 1
`define PBS_STATUS_FIXED 16'h0210
`define PBS_ST_PAR_DET 15
`define PBS_ST_SERR_SIG 14
`define PBS_ST_MABORT_RCV 13
`define PBS_ST_TABORT_RCV 12
`define PBS_ST_TABORT_SIG 11
`define PBS_ST_MDPERR 8
`define PBS_NUM_FLAGS 6

`endif

// ==== rtl/pbs_pkg.sv ====
package pbs_pkg;
  typedef logic [15:0] pbs_half_t;
  typedef logic [31:0] pbs_dword_t;
  typedef logic [5:0] pbs_flags_t;
endpackage

// ==== rtl/pbs_w1c_flag.sv ====
`timescale 1ns/1ps
module pbs_w1c_flag (
  input wire logic clk,
  input wire logic rstn,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  // set is tested first so an event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1; // see RULE17
    end else if (clr) begin
      q <= 1'b0; // see RULE1
    end
  end
endmodule

// ==== rtl/pbs_primary_status.sv ====
// What this block does
// RULE1: write one clears flag, zero leaves it
// RULE2: status at offset 06h, resets to 0210h
// RULE3: bit 15 sets on detected parity error
// RULE4: bit 14 sets on enabled system error
// RULE5: bit 13 sets on received master abort
// RULE6: bit 12 sets on received target abort
// RULE7: bit 11 sets on signaled target abort
// RULE8: bits 10-9 read-only, return 01b
// RULE9: bit 8 needs pin, mastership, response enable
// RULE10: bit 7 read-only zero
// RULE11: bit 6 read-only zero
// RULE12: bit 5 read-only zero, no 66 MHz
// RULE13: bit 4 read-only one, capabilities list
// RULE14: bits 3-0 reserved, read zero
// RULE15: command bit 8 enables system error driver
// RULE16: command bit 6 enables parity response
// RULE17: set beats simultaneous write-one clear
// RULE18: writes to fixed status bits ignored
`timescale 1ns/1ps
`include "pbs_defines.svh"
module pbs_primary_status (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output pbs_pkg::pbs_dword_t cfg_rdata,
  output logic cfg_ack,
  input wire logic parity_error_detected,
  input wire logic serr_asserted,
  input wire logic master_abort_received,
  input wire logic target_abort_received,
  input wire logic target_abort_signaled,
  input wire logic bridge_is_master,
  input wire logic primary_parity_error_pin_n,
  output logic serr_driver_enable,
  output logic parity_response_enable,
  output pbs_pkg::pbs_half_t status
);
  pbs_pkg::pbs_half_t cmd;
  pbs_pkg::pbs_flags_t flag_set;
  pbs_pkg::pbs_flags_t flag_clr;
  pbs_pkg::pbs_flags_t flag_q;
  pbs_pkg::pbs_half_t next_status;
  pbs_pkg::pbs_half_t next_cmd;
  logic hit;
  logic wr_hit;
  // split per byte lane so each masked lane keeps its own width
  localparam pbs_pkg::pbs_half_t CMD_WMASK = `PBS_CMD_WMASK;

  // the whole command/status pair lives in one configuration dword
  assign hit = (cfg_addr == `PBS_CFG_DWORD_OFS);
  assign wr_hit = cfg_wr & hit;

  // events come from logic on the primary clock, so no synchroniser
  assign flag_set[5] = parity_error_detected; // see RULE3
  assign flag_set[4] = serr_asserted & cmd[`PBS_CMD_SERR_EN]; // see RULE4
  assign flag_set[3] = master_abort_received; // see RULE5
  assign flag_set[2] = target_abort_received; // see RULE6
  assign flag_set[1] = target_abort_signaled; // see RULE7
  assign flag_set[0] = ~primary_parity_error_pin_n & bridge_is_master
                       & cmd[`PBS_CMD_PERR_RESP]; // see RULE9

  // byte lane 3 carries status bits 15..8, bit 8 included; lane 2 holds nothing writable
  assign flag_clr[5] = wr_hit & cfg_be[3] & cfg_wdata[16 + `PBS_ST_PAR_DET];
  assign flag_clr[4] = wr_hit & cfg_be[3] & cfg_wdata[16 + `PBS_ST_SERR_SIG];
  assign flag_clr[3] = wr_hit & cfg_be[3] & cfg_wdata[16 + `PBS_ST_MABORT_RCV];
  assign flag_clr[2] = wr_hit & cfg_be[3] & cfg_wdata[16 + `PBS_ST_TABORT_RCV];
  assign flag_clr[1] = wr_hit & cfg_be[3] & cfg_wdata[16 + `PBS_ST_TABORT_SIG];
  assign flag_clr[0] = wr_hit & cfg_be[3] & cfg_wdata[16 + `PBS_ST_MDPERR];

  genvar i;
  generate
    for (i = 0; i < `PBS_NUM_FLAGS; i = i + 1) begin : g_flag
      pbs_w1c_flag u_flag (
        .clk(clk),
        .rstn(rstn),
        .set(flag_set[i]),
        .clr(flag_clr[i]),
        .q(flag_q[i])
      );
    end
  endgenerate

  // fixed fields come only from the constant, so writes cannot reach them
  always_comb begin
    next_status = `PBS_STATUS_FIXED; // see RULE8 see RULE13 see RULE18
    next_status[7] = 1'b0; // see RULE10
    next_status[6] = 1'b0; // see RULE11
    next_status[5] = 1'b0; // see RULE12
    next_status[3:0] = 4'h0; // see RULE14
    next_status[`PBS_ST_PAR_DET] = flag_q[5];
    next_status[`PBS_ST_SERR_SIG] = flag_q[4];
    next_status[`PBS_ST_MABORT_RCV] = flag_q[3];
    next_status[`PBS_ST_TABORT_RCV] = flag_q[2];
    next_status[`PBS_ST_TABORT_SIG] = flag_q[1];
    next_status[`PBS_ST_MDPERR] = flag_q[0];
  end

  // status output lags the flags by one cycle so it comes from a flop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status <= `PBS_STATUS_RESET; // see RULE2
    end else begin
      status <= next_status;
    end
  end

  always_comb begin
    next_cmd = cmd;
    if (wr_hit && cfg_be[0]) begin
      next_cmd[7:0] = cfg_wdata[7:0] & CMD_WMASK[7:0];
    end
    if (wr_hit && cfg_be[1]) begin
      next_cmd[15:8] = cfg_wdata[15:8] & CMD_WMASK[15:8];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd <= `PBS_CMD_RESET;
      serr_driver_enable <= 1'b0;
      parity_response_enable <= 1'b0;
    end else begin
      cmd <= next_cmd;
      serr_driver_enable <= next_cmd[`PBS_CMD_SERR_EN]; // see RULE15
      parity_response_enable <= next_cmd[`PBS_CMD_PERR_RESP]; // see RULE16
    end
  end

  // one-cycle acknowledge; other dwords belong to other blocks, read zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_ack <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_ack <= cfg_rd | cfg_wr;
      if (cfg_rd && hit) begin
        cfg_rdata <= {next_status, cmd}; // see RULE2
      end else begin
        cfg_rdata <= 32'h0000_0000;
      end
    end
  end
endmodule

// ==== tb/pbs_primary_status_checker.sv ====
`timescale 1ns/1ps
module pbs_primary_status_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic parity_error_detected,
  input wire logic serr_asserted,
  input wire logic master_abort_received,
  input wire logic target_abort_received,
  input wire logic target_abort_signaled,
  input wire logic bridge_is_master,
  input wire logic primary_parity_error_pin_n,
  input wire logic serr_driver_enable,
  input wire logic parity_response_enable,
  input pbs_pkg::pbs_half_t status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic clr;
  logic w15;
  assign clr = cfg_wr && cfg_be[3] && cfg_addr == 8'h04;
  assign w15 = clr && cfg_wdata[31];
  // a clear right after the event may legally hide it, so skip that case
  property p_set(e, b);
    e ##1 !clr |-> ##[1:2] b;
  endproperty
  a_fixed_bits:
    assert property ((status & 16'h06FF) == 16'h0210) else $error("fixed");
  a_par_set:
    assert property (p_set(parity_error_detected, status[15])) else $error("b15");
  a_serr_set:
    assert property (p_set(serr_asserted && serr_driver_enable, status[14]))
    else $error("b14");
  a_mabort_set:
    assert property (p_set(master_abort_received, status[13])) else $error("b13");
  a_tabort_rcv:
    assert property (p_set(target_abort_received, status[12])) else $error("b12");
  a_tabort_sig:
    assert property (p_set(target_abort_signaled, status[11])) else $error("b11");
  a_mdperr_set:
    assert property (p_set(bridge_is_master && !primary_parity_error_pin_n
      && parity_response_enable, status[8])) else $error("b8");
  a_w1c_only:
    assert property ($fell(status[15]) |-> $past(w15) || $past(w15, 2))
    else $error("b15 lost");
  c_clear: cover property (clr);
  c_serr: cover property (serr_asserted && serr_driver_enable);
  c_mdperr: cover property (bridge_is_master && !primary_parity_error_pin_n);
endmodule

// ==== tb/pbs_bus_agent.sv ====
`timescale 1ns/1ps
// primary bus agents; ev[6] pulls the low-active parity error pin
module pbs_bus_agent (
  input wire logic [6:0] ev,
  output logic parity_error_detected,
  output logic serr_asserted,
  output logic master_abort_received,
  output logic target_abort_received,
  output logic target_abort_signaled,
  output logic bridge_is_master,
  output logic primary_parity_error_pin_n
);
  assign {primary_parity_error_pin_n, bridge_is_master, target_abort_signaled,
    target_abort_received, master_abort_received, serr_asserted,
    parity_error_detected} = ev ^ 7'h40;
endmodule

// ==== tb/test_bridge_primary_status.sv ====
`timescale 1ns/1ps
module test_bridge_primary_status;
  logic clk = 0, rstn = 0, cfg_rd = 0, cfg_wr = 0, cfg_ack;
  logic [7:0] cfg_addr = 8'h0;
  logic [3:0] cfg_be = 4'h0;
  logic [6:0] ev = 7'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, r;
  logic parity_error_detected, serr_asserted, master_abort_received;
  logic target_abort_received, target_abort_signaled, bridge_is_master;
  logic primary_parity_error_pin_n, serr_driver_enable, parity_response_enable;
  logic [15:0] status;
  int error_cnt = 0, check_count = 0, cyc = 0;
  always #10 clk = ~clk;
  pbs_primary_status u_pbs_primary_status (.*);
  pbs_bus_agent u_pbs_bus_agent (.*);
  always @(posedge clk) if (++cyc == 2000) begin
    error_cnt++;
    end_of_test;
  end
  task chk(input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %0t got %h want %h", $time, s, e);
    end
  endtask
  // reads go out whenever no write does, so events may ride along
  task cfg(input logic w, input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] d, input logic [6:0] e);
    @(posedge clk);
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata, ev} <= {w, !w, a, b, d, e};
    @(posedge clk);
    {cfg_wr, cfg_rd, ev} <= 9'h0;
    #1 r = cfg_rdata;
    chk(32'(cfg_ack), 32'h1);
  endtask
  task t_regs;
    cfg(0, 8'h04, 4'h0, 32'h0, 7'h0);
    chk(r, 32'h02100000);
    cfg(0, 8'h08, 4'h0, 32'h0, 7'h0);
    chk(r, 32'h0);
    cfg(1, 8'h04, 4'hF, 32'hFFFFFFFF, 7'h0);
    cfg(0, 8'h04, 4'h0, 32'h0, 7'h0);
    chk(r, 32'h02100367);
    chk(32'({serr_driver_enable, parity_response_enable}), 32'h3);
  endtask
  task t_events;
    cfg(0, 8'h04, 4'h0, 32'h0, 7'h7F);
    cfg(1, 8'h04, 4'hC, 32'h0, 7'h0);
    cfg(0, 8'h04, 4'h0, 32'h0, 7'h0);
    chk(r, 32'hFB100367);
    cfg(1, 8'h04, 4'hC, 32'hFFFF0000, 7'h01);
    cfg(0, 8'h04, 4'h0, 32'h0, 7'h0);
    chk(r, 32'h82100367);
    chk(32'(status), 32'h00008210);
  endtask
  task t_gating;
    cfg(1, 8'h04, 4'hF, 32'h80000000, 7'h0);
    cfg(0, 8'h04, 4'h0, 32'h0, 7'h62);
    cfg(1, 8'h04, 4'h3, 32'h00000040, 7'h0);
    cfg(0, 8'h04, 4'h0, 32'h0, 7'h40);
    cfg(0, 8'h04, 4'h0, 32'h0, 7'h0);
    chk(r, 32'h02100040);
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1;
    t_regs;
    t_events;
    t_gating;
    end_of_test;
  end
endmodule
bind pbs_primary_status pbs_primary_status_checker u_chk (.*);
